// [mcavg_top.v]
// Calculation-block pipeline with averaging filters and AXI4-Lite port.
// Assumes the upstream front end delivers corrected raw values in order.
// Function
// - Ten blocks, evaluated in fixed order
// - Sources only raw or earlier block results
// - Blocks run after front end, before statistics
// - Averaging after computation, before any output
// - One output per input measurement
// - Averaging off after reset, values pass
// - Moving average over latest N samples
// - Moving window power of two, max 512
// - Recursive: (x+(N-1)*prev)/N, N to 32768
// - Median: middle of sorted latest window
// - Median window three, five, seven, nine
// - Weighted sum: f1*A + f2*B + offset
// - Thickness: B minus A
// - Two sources for sum/thickness, averages one
`include "mcavg_consts.vh"

// ******************************
// Output FIFO
// ******************************
module mcavg_fifo #(
  parameter W = 32,
  parameter D = 8,
  parameter AW = 3
) (
  input wire core_clk, // System clock
  input wire rst_n, // Async reset, low active
  input wire in_valid, // Write request
  output wire in_ready, // Space available
  input wire [W-1:0] in_data, // Write data
  output wire out_valid, // Data available
  input wire out_ready, // Sink takes a word
  output wire [W-1:0] out_data // Head word
);
  reg [W-1:0] mem_q [0:D-1]; // Storage
  reg [AW-1:0] wp_q; // Write index
  reg [AW-1:0] rp_q; // Read index
  reg [AW:0] cnt_q; // Fill level
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_q != D[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rp_q];
  // Storage is written without reset; only the indices matter
  always @(posedge core_clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end
  // Index and level bookkeeping
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_q <= (wp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // mcavg_fifo

// ******************************
// Top level
// ******************************
module mcavg_top (
  input wire core_clk, // 50 MHz clock
  input wire rst_n, // Async reset, low active
  input wire in_valid, // Raw measurement offered
  output wire in_ready, // Raw measurement taken
  input wire [127:0] measured_value_in, // Four raw signals, 32b each
  output wire out_valid, // Result available
  input wire out_ready, // Sink takes result
  output wire [31:0] out_data, // Selected result
  input wire [11:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  output wire s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Byte enables
  input wire s_axi_wvalid, // Write data valid
  output wire s_axi_wready, // Write data ready
  output wire [1:0] s_axi_bresp, // Write response
  output wire s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [11:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  output wire s_axi_arready, // Read address ready
  output wire [31:0] s_axi_rdata, // Read data
  output wire [1:0] s_axi_rresp, // Read response
  output wire s_axi_rvalid, // Read data valid
  input wire s_axi_rready // Read data ready
);
  localparam S_IDLE = 2'h0; // Waiting for a measurement
  localparam S_EVAL = 2'h1; // Evaluating block k
  localparam S_DIV = 2'h2; // Serial divide for block k
  localparam S_PUSH = 2'h3; // Handing result to FIFO

  reg [31:0] cfg_q [0:9]; // Program, sources, parameter
  reg [31:0] fac_q [0:9]; // Factor 2 : factor 1
  reg [31:0] ofs_q [0:9]; // Offset
  reg [31:0] ctrl_q; // Output signal select
  reg [31:0] sig_q [0:13]; // Raw signals then block results
  reg [31:0] mov_mem [0:5119]; // Moving windows, 512 per block
  reg [31:0] med_mem [0:89]; // Median windows, 9 per block
  reg [9:0] cnt_q [0:9]; // Samples held per block
  reg [8:0] ptr_q [0:9]; // Ring index per block
  reg [47:0] sum_q [0:9]; // Moving window sum
  reg [31:0] prev_q [0:9]; // Recursive previous output
  reg [1:0] st_q; // Sequencer state
  reg [3:0] k_q; // Current block
  reg [31:0] meas_q; // Measurements completed
  reg [47:0] dq_q; // Divider quotient/dividend
  reg [16:0] dr_q; // Divider remainder
  reg [15:0] dd_q; // Divider divisor
  reg dneg_q; // Quotient sign
  reg [5:0] dstep_q; // Divider step
  integer i, j, r, less, eq, base;

  // ******************************
  // Block decode
  // ******************************
  wire [31:0] cfg = cfg_q[k_q];
  wire [2:0] prog = cfg[`MC_F_PROG];
  wire [15:0] par = cfg[`MC_F_PAR];
  wire [3:0] lim = k_q + `MC_SIG_OFS;
  wire [3:0] res_idx = lim;
  // Out-of-order sources fall back to raw signal 0, so no loop forms
  wire [3:0] sa = (cfg[`MC_F_SRCA] < lim) ? cfg[`MC_F_SRCA] : 4'h0;
  wire [3:0] sb = (cfg[`MC_F_SRCB] < lim) ? cfg[`MC_F_SRCB] : 4'h0;
  wire signed [31:0] a = sig_q[sa];
  wire signed [31:0] b = sig_q[sb];
  wire [9:0] cnt = cnt_q[k_q];
  wire [8:0] ptr = ptr_q[k_q];

  // Moving average: clamp log2 window so N stays a power of two
  wire [3:0] mlg = (par[3:0] > `MC_MOV_LG_MAX) ? `MC_MOV_LG_MAX
                   : par[3:0];
  wire [9:0] nwin = 10'h001 << mlg;
  wire mfull = (cnt >= nwin);
  wire [12:0] midx = {k_q, ptr};
  wire signed [47:0] mold = {{16{mov_mem[midx][31]}}, mov_mem[midx]};
  wire signed [47:0] msum_d = mfull ? sum_q[k_q] + {{16{a[31]}}, a} - mold
                              : sum_q[k_q] + {{16{a[31]}}, a};
  wire [9:0] mcnt_d = mfull ? cnt : cnt + 10'h001;

  // Recursive average: N in 1..32768
  wire [15:0] nrec = (par == 16'h0000) ? 16'h0001
                     : (par > `MC_REC_N_MAX) ? `MC_REC_N_MAX : par;
  wire [16:0] nm1 = {1'b0, nrec - 16'h0001};
  wire signed [48:0] rprod = $signed(nm1) * $signed(prev_q[k_q]);
  wire signed [47:0] rnum = rprod[47:0] + {{16{a[31]}}, a};

  // Median window forced to an odd size from three to nine
  wire [3:0] mw = (par[3:0] < `MC_MED_MIN) ? `MC_MED_MIN
                  : (par[3:0] > `MC_MED_MAX) ? `MC_MED_MAX
                  : {par[3:1], 1'b1};
  wire [9:0] wn = {6'h00, mw};
  wire [9:0] dn = (cnt >= wn) ? wn : cnt + 10'h001;
  reg [31:0] win [0:8]; // Window with newest sample placed
  reg [31:0] med; // Median of window
  // Rank each entry; the one that straddles the middle is the median
  always @* begin
    med = a;
    base = k_q * 9;
    for (i = 0; i < 9; i = i + 1) begin
      win[i] = (i == ptr) ? a : med_mem[base + i];
    end
    for (i = 0; i < 9; i = i + 1) begin
      less = 0;
      eq = 0;
      for (j = 0; j < 9; j = j + 1) begin
        if (j < dn && $signed(win[j]) < $signed(win[i])) begin
          less = less + 1;
        end else if (j < dn && win[j] == win[i]) begin
          eq = eq + 1;
        end
      end
      if (i < dn && 2 * less < dn && 2 * (less + eq) >= dn) begin
        med = win[i];
      end
    end
  end

  // Direct results of the single-cycle programs
  wire signed [47:0] p1 = $signed(fac_q[k_q][15:0]) * a;
  wire signed [47:0] p2 = $signed(fac_q[k_q][31:16]) * b;
  wire [47:0] wsum = p1 + p2 + {{16{ofs_q[k_q][31]}}, ofs_q[k_q]};
  reg [31:0] res; // Result when no divide is needed
  always @* begin
    case (prog)
      `MC_P_THK: res = b - a;
      `MC_P_SUM: res = wsum[31:0];
      `MC_P_MED: res = med;
      default: res = a;
    endcase
  end

  // ******************************
  // Serial divider, truncates toward zero
  // ******************************
  wire [16:0] dsh = {dr_q[15:0], dq_q[47]};
  wire dge = (dsh >= {1'b0, dd_q});
  wire [47:0] qfin = {dq_q[46:0], dge};
  wire [31:0] qres = dneg_q ? 32'h00000000 - qfin[31:0] : qfin[31:0];
  wire dlast = (dstep_q == `MC_DIV_LAST);
  wire sdiv = (prog == `MC_P_MOV) ||
              (prog == `MC_P_REC && cnt != 10'h000);
  wire signed [47:0] dnum = (prog == `MC_P_MOV) ? msum_d : rnum;
  wire [15:0] dden = (prog == `MC_P_MOV) ? {6'h00, mcnt_d} : nrec;

  // ******************************
  // Sequencer
  // ******************************
  wire fifo_ready;
  assign in_ready = (st_q == S_IDLE);
  wire in_go = in_valid && in_ready;
  wire [3:0] osel = (ctrl_q[3:0] > `MC_NSIG_MAX) ? 4'h0 : ctrl_q[3:0];
  wire wr_go;
  wire wcfg_hit;
  wire [3:0] wbk;

  // Window storage has no reset; the counts say what is valid
  always @(posedge core_clk) begin
    if (st_q == S_EVAL && prog == `MC_P_MOV) begin
      mov_mem[midx] <= a;
    end
    if (st_q == S_EVAL && prog == `MC_P_MED) begin
      med_mem[k_q * 9 + ptr] <= a;
    end
  end

  // Blocks are walked 0..9 per measurement, one result pushed at the end
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_IDLE;
      k_q <= 4'h0;
      meas_q <= 32'h00000000;
      dq_q <= 48'h000000000000;
      dr_q <= 17'h00000;
      dd_q <= 16'h0001;
      dneg_q <= 1'b0;
      dstep_q <= 6'h00;
      for (r = 0; r < 14; r = r + 1) begin
        sig_q[r] <= 32'h00000000;
      end
      for (r = 0; r < 10; r = r + 1) begin
        cnt_q[r] <= 10'h000;
        ptr_q[r] <= 9'h000;
        sum_q[r] <= 48'h000000000000;
        prev_q[r] <= 32'h00000000;
      end
    end else begin
      case (st_q)
        S_IDLE: begin
          if (in_go) begin
            // Raw values arrive already corrected by the front end
            for (r = 0; r < 4; r = r + 1) begin
              sig_q[r] <= measured_value_in[32*r +: 32];
            end
            k_q <= 4'h0;
            st_q <= S_EVAL;
          end
        end
        S_EVAL: begin
          if (prog == `MC_P_MOV) begin
            sum_q[k_q] <= msum_d;
            cnt_q[k_q] <= mcnt_d;
            ptr_q[k_q] <= (ptr + 9'h001) & (nwin[8:0] - 9'h001);
          end
          if (prog == `MC_P_MED) begin
            cnt_q[k_q] <= dn;
            ptr_q[k_q] <= (ptr + 9'h001 >= {5'h00, mw}) ? 9'h000
                          : ptr + 9'h001;
          end
          if (prog == `MC_P_REC && cnt == 10'h000) begin
            prev_q[k_q] <= a;
            cnt_q[k_q] <= 10'h001;
          end
          if (sdiv) begin
            dneg_q <= dnum[47];
            dq_q <= dnum[47] ? 48'h000000000000 - dnum : dnum;
            dr_q <= 17'h00000;
            dd_q <= dden;
            dstep_q <= 6'h00;
            st_q <= S_DIV;
          end else begin
            sig_q[res_idx] <= res;
            k_q <= k_q + 4'h1;
            st_q <= (k_q == `MC_LAST_BLK) ? S_PUSH : S_EVAL;
          end
        end
        S_DIV: begin
          dq_q <= qfin;
          dr_q <= dge ? dsh - {1'b0, dd_q} : dsh;
          dstep_q <= dstep_q + 6'h01;
          if (dlast) begin
            sig_q[res_idx] <= qres;
            if (prog == `MC_P_REC) begin
              prev_q[k_q] <= qres;
            end
            k_q <= k_q + 4'h1;
            st_q <= (k_q == `MC_LAST_BLK) ? S_PUSH : S_EVAL;
          end
        end
        S_PUSH: begin
          // Stall here while the FIFO is full; input waits meanwhile
          if (fifo_ready) begin
            meas_q <= meas_q + 32'h00000001;
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
      // A new program or parameter restarts that block's history
      if (wr_go && wcfg_hit) begin
        cnt_q[wbk] <= 10'h000;
        ptr_q[wbk] <= 9'h000;
        sum_q[wbk] <= 48'h000000000000;
      end
    end
  end

  mcavg_fifo #(.W(32), .D(`MC_FIFO_DEPTH), .AW(3)) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(st_q == S_PUSH),
    .in_ready(fifo_ready),
    .in_data(sig_q[osel]),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );

  // ******************************
  // AXI4-Lite slave
  // ******************************
  reg aw_q; // Write address held
  reg w_q; // Write data held
  reg [11:0] wa_q; // Held write address
  reg [31:0] wd_q; // Held write data
  reg [3:0] ws_q; // Held byte enables
  reg bv_q; // Write response pending
  reg [1:0] br_q; // Write response code
  reg rv_q; // Read data pending
  reg [1:0] rr_q; // Read response code
  reg [31:0] rd_q; // Read data
  assign s_axi_awready = !aw_q && !bv_q;
  assign s_axi_wready = !w_q && !bv_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = br_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rresp = rr_q;
  assign s_axi_rdata = rd_q;
  assign wr_go = aw_q && w_q && !bv_q;
  wire wblk = (wa_q[11:8] == 4'h0) && (wa_q[7:4] >= `MC_BLK_LO) &&
              (wa_q[7:4] < `MC_BLK_HI);
  assign wbk = wa_q[7:4] - `MC_BLK_LO;
  assign wcfg_hit = wblk && (wa_q[3:2] == `MC_S_CFG);
  wire wmap = wblk || ({wa_q[11:2], 2'h0} == `MC_A_CTRL) ||
              ({wa_q[11:2], 2'h0} == `MC_A_STAT);
  wire rblk = (s_axi_araddr[11:8] == 4'h0) &&
              (s_axi_araddr[7:4] >= `MC_BLK_LO) &&
              (s_axi_araddr[7:4] < `MC_BLK_HI);
  wire [3:0] rbk = s_axi_araddr[7:4] - `MC_BLK_LO;
  wire [11:0] rwa = {s_axi_araddr[11:2], 2'h0};

  // Byte-lane merge for partial writes
  function [31:0] wmrg(input [31:0] o, input [31:0] d, input [3:0] s);
    integer n;
    begin
      for (n = 0; n < 4; n = n + 1) begin
        wmrg[8*n +: 8] = s[n] ? d[8*n +: 8] : o[8*n +: 8];
      end
    end
  endfunction

  // Channels are taken independently; the write acts once both are in
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      wa_q <= 12'h000;
      wd_q <= 32'h00000000;
      ws_q <= 4'h0;
      bv_q <= 1'b0;
      br_q <= 2'h0;
      rv_q <= 1'b0;
      rr_q <= 2'h0;
      rd_q <= 32'h00000000;
      ctrl_q <= `MC_CTRL_RST;
      for (r = 0; r < 10; r = r + 1) begin
        cfg_q[r] <= 32'h00000000;
        fac_q[r] <= 32'h00000000;
        ofs_q[r] <= 32'h00000000;
      end
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        wa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bv_q <= 1'b1;
        br_q <= wmap ? 2'h0 : 2'h2;
        if ({wa_q[11:2], 2'h0} == `MC_A_CTRL) begin
          ctrl_q <= wmrg(ctrl_q, wd_q, ws_q);
        end
        if (wblk && wa_q[3:2] == `MC_S_CFG) begin
          cfg_q[wbk] <= wmrg(cfg_q[wbk], wd_q, ws_q);
        end
        if (wblk && wa_q[3:2] == `MC_S_FAC) begin
          fac_q[wbk] <= wmrg(fac_q[wbk], wd_q, ws_q);
        end
        if (wblk && wa_q[3:2] == `MC_S_OFS) begin
          ofs_q[wbk] <= wmrg(ofs_q[wbk], wd_q, ws_q);
        end
      end else if (bv_q && s_axi_bready) begin
        bv_q <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        rv_q <= 1'b1;
        rr_q <= 2'h0;
        if (rwa == `MC_A_CTRL) begin
          rd_q <= ctrl_q;
        end else if (rwa == `MC_A_STAT) begin
          rd_q <= {meas_q[15:0], 14'h0000, st_q};
        end else if (rblk) begin
          case (s_axi_araddr[3:2])
            `MC_S_CFG: rd_q <= cfg_q[rbk];
            `MC_S_FAC: rd_q <= fac_q[rbk];
            `MC_S_OFS: rd_q <= ofs_q[rbk];
            default: rd_q <= sig_q[rbk + `MC_SIG_OFS];
          endcase
        end else begin
          rd_q <= 32'h00000000;
          rr_q <= 2'h2;
        end
      end else if (rv_q && s_axi_rready) begin
        rv_q <= 1'b0;
      end
    end
  end
endmodule // mcavg_top

// [mcavg_consts.vh]
// Constants for the measurement calculation and averaging block.
// Assumes a 32-bit AXI4-Lite register port and 32-bit signed samples.
`ifndef MCAVG_CONSTS_VH
`define MCAVG_CONSTS_VH
// ******************************
// Sizes
// ******************************
`define MC_NRAW 4
`define MC_NBLK 10
`define MC_LAST_BLK 4'h9
`define MC_SIG_OFS 4'h4
`define MC_NSIG_MAX 4'hd
`define MC_FIFO_DEPTH 8
`define MC_DIV_LAST 6'h2f
// ******************************
// Register map (byte addresses)
// ******************************
`define MC_A_CTRL 12'h000
`define MC_A_STAT 12'h004
`define MC_BLK_LO 4'h4
`define MC_BLK_HI 4'he
`define MC_S_CFG 2'h0
`define MC_S_FAC 2'h1
`define MC_S_OFS 2'h2
`define MC_S_RES 2'h3
`define MC_CTRL_RST 32'h00000004
// ******************************
// Block config fields and programs
// ******************************
`define MC_F_PROG 2:0
`define MC_F_SRCA 7:4
`define MC_F_SRCB 11:8
`define MC_F_PAR 31:16
`define MC_P_OFF 3'h0
`define MC_P_MOV 3'h1
`define MC_P_REC 3'h2
`define MC_P_MED 3'h3
`define MC_P_THK 3'h4
`define MC_P_SUM 3'h5
`define MC_P_DUP 3'h6
`define MC_MOV_LG_MAX 4'h9
`define MC_MED_MIN 4'h3
`define MC_MED_MAX 4'h9
`define MC_REC_N_MAX 16'h8000
`endif

// [mcavg_assertions.sv]
// Port checks for the calculation-block pipeline.
// Assumes one clock, core_clk, and async low-active reset rst_n.
module mcavg_assertions (
  input wire logic core_clk, // Clock
  input wire logic rst_n, // Reset, low active
  input wire logic in_valid, // Sample offered
  input wire logic in_ready, // Sample taken
  input wire logic out_valid, // Result present
  input wire logic out_ready, // Result popped
  input wire logic [31:0] out_data, // Head result
  input wire logic s_axi_awvalid, // AW valid
  input wire logic s_axi_awready, // AW ready
  input wire logic s_axi_wvalid, // W valid
  input wire logic s_axi_wready, // W ready
  input wire logic [1:0] s_axi_bresp, // B code
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_bready, // B ready
  input wire logic s_axi_arvalid, // AR valid
  input wire logic s_axi_arready, // AR ready
  input wire logic [31:0] s_axi_rdata, // R data
  input wire logic s_axi_rvalid, // R valid
  input wire logic s_axi_rready // R ready
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ****************
  // Output count
  // ****************
  logic rdy_q; // in_ready one cycle back
  logic [4:0] occ_q; // Words held, less a push made at the last edge
  logic [4:0] occ_cur; // Words held now
  // A rise of in_ready marks the push one edge before it
  assign occ_cur = occ_q + {4'h0, in_ready & ~rdy_q};
  // Reset to idle so release does not look like a push
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy_q <= 1'h1;
      occ_q <= 5'h00;
    end else begin
      rdy_q <= in_ready;
      occ_q <= occ_cur - {4'h0, out_valid & out_ready};
    end
  end
  // ****************
  // Properties
  // ****************
  sequence s_take;
    in_valid && in_ready;
  endsequence
  // Ten blocks plus the push keep the input closed eleven cycles
  sequence s_busy;
    !in_ready [*8] ##1 !in_ready [*3];
  endsequence
  sequence s_aw_w;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  AST_TAKE_DONE: assert property (
    s_take |=> s_busy ##[1:800] in_ready)
    else $error("measurement pass too short or too long");
  AST_READY_CAUSE: assert property (
    $fell(in_ready) |-> $past(in_valid))
    else $error("input closed without a take");
  AST_ONE_OUT: assert property (
    out_valid == (occ_cur != 5'h00))
    else $error("result words differ from measurements");
  AST_OUT_HOLD: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("result changed before pop");
  AST_B_ANS: assert property (
    s_aw_w |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response at wrong cycle");
  AST_B_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_ANS: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_R_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule // mcavg_assertions

bind mcavg_top mcavg_assertions u_chk (.*);

// [mcavg_src_model.sv]
// Upstream front-end model offering raw measurements by valid/ready.
// Assumes send is called from one process, right after a rising edge.
module mcavg_src_model (
  input wire logic core_clk, // Clock
  input wire logic rst_n, // Reset, low active
  input wire logic in_ready, // Pipeline takes sample
  output logic in_valid, // Sample offered
  output logic [127:0] measured_value_in // Four raw signals
);
  // ****************
  // Sender
  // ****************
  initial begin
    in_valid = 1'h0;
    measured_value_in = 128'h0;
  end
  // Gap of one or more edges keeps back-to-back sends legal
  // Ready is sampled mid-cycle, since it falls at the very edge it is taken
  task automatic send(input logic [127:0] v, input int gap);
    logic ok;
    repeat (gap) @(posedge core_clk);
    in_valid <= 1'h1;
    measured_value_in <= v;
    do begin
      @(negedge core_clk);
      ok = (in_ready === 1'h1) && rst_n;
      @(posedge core_clk);
    end while (!ok);
    in_valid <= 1'h0;
    measured_value_in <= ~v; // Stale data must not look valid
  endtask
endmodule // mcavg_src_model

// [mcavg_top_test.sv]
// Self-checking bench for the calculation-block pipeline.
// Assumes mcavg_top, the source model and the checker are compiled.
`include "mcavg_consts.vh"
module mcavg_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'h0; // 50 MHz clock
  logic rst_n = 1'h0; // Reset, low active
  logic in_valid, in_ready, out_valid; // Stream flags
  logic out_ready = 1'h0; // Sink pop
  logic [127:0] measured_value_in; // Raw signals
  logic [31:0] out_data, s_axi_rdata; // Result and read data
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0; // Addresses
  logic [31:0] s_axi_wdata = 32'h0; // Write data
  logic [3:0] s_axi_wstrb = 4'h0; // Byte lanes
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0; // Read requests
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid; // Read answer
  logic [1:0] s_axi_bresp, s_axi_rresp; // Response codes
  int errors = 0; // Mismatches
  int num_checks = 0; // Comparisons
  always #10 core_clk = ~core_clk; // 20 ns period
  mcavg_top u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .in_valid(in_valid),
    .in_ready(in_ready), .measured_value_in(measured_value_in),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );
  mcavg_src_model u_src (
    .core_clk(core_clk), .rst_n(rst_n), .in_ready(in_ready),
    .in_valid(in_valid), .measured_value_in(measured_value_in)
  );
  // ****************
  // Helpers
  // ****************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask
  // Answers are sampled mid-cycle; the edge itself races the slave
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
    input logic [1:0] er, input logic [3:0] st = 4'hf);
    logic ra, rw, rb;
    logic [1:0] rs;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge core_clk);
      {ra, rw, rb, rs} = {s_axi_awready, s_axi_wready, s_axi_bvalid,
        s_axi_bresp};
      @(posedge core_clk);
      if (ra) s_axi_awvalid <= 1'h0;
      if (rw) s_axi_wvalid <= 1'h0;
    end while (rb !== 1'h1);
    s_axi_bready <= 1'h0;
    chk({30'h0, rs}, {30'h0, er});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ed,
    input logic [1:0] er);
    logic ra, rv;
    logic [33:0] rx;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge core_clk);
      {ra, rv, rx} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge core_clk);
      if (ra) s_axi_arvalid <= 1'h0;
    end while (rv !== 1'h1);
    s_axi_rready <= 1'h0;
    chk(rx[33:2], ed);
    chk({30'h0, rx[1:0]}, {30'h0, er});
  endtask
  task automatic get(input logic [31:0] e, input bit c = 1'h1);
    logic v;
    logic [31:0] dv;
    @(posedge core_clk);
    out_ready <= 1'h1;
    do begin
      @(negedge core_clk);
      {v, dv} = {out_valid, out_data};
      @(posedge core_clk);
    end while (v !== 1'h1);
    out_ready <= 1'h0;
    if (c) chk(dv, e);
  endtask
  function automatic logic [31:0] cw(input logic [2:0] p,
    input logic [3:0] a, input logic [3:0] b, input logic [15:0] n);
    return {n, 4'h0, b, a, 1'h0, p};
  endfunction
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset;
    rd(`MC_A_CTRL, `MC_CTRL_RST, 2'h0);
    rd(12'h040, 32'h0, 2'h0);
    u_src.send({96'h0, 32'h00001234}, 1);
    get(32'h00001234);
    $display("t_reset done");
  endtask
  task automatic t_mov;
    int v[7] = '{0, 1, 2, 2, 1, 3, 4};
    int s;
    wr(`MC_A_CTRL, 32'h4, 2'h0);
    wr(12'h040, cw(`MC_P_MOV, 4'h0, 4'h0, 16'h2), 2'h0);
    for (int i = 0; i < 7; i++) begin
      u_src.send({96'h0, 32'(v[i])}, i % 3 + 1);
      s = 0;
      for (int j = (i > 3) ? i - 3 : 0; j <= i; j++) s += v[j];
      get(32'(s / ((i > 3) ? 4 : i + 1)));
    end
    wr(12'h040, cw(`MC_P_MOV, 4'h0, 4'h0, 16'h2), 2'h0);
    u_src.send({96'h0, 32'h8}, 1);
    get(32'h8);
    $display("t_mov done");
  endtask
  task automatic t_rec;
    int v[4] = '{100, 0, 0, 40};
    int m;
    wr(12'h040, cw(`MC_P_REC, 4'h0, 4'h0, 16'h4), 2'h0);
    for (int i = 0; i < 4; i++) begin
      u_src.send({96'h0, 32'(v[i])}, 1);
      m = (i == 0) ? v[0] : (v[i] + 3 * m) / 4;
      get(32'(m));
    end
    $display("t_rec done");
  endtask
  task automatic t_med;
    for (int w = 3; w <= 9; w += 2) begin
      wr(12'h040, cw(`MC_P_MED, 4'h0, 4'h0, 16'(w)), 2'h0);
      for (int i = 0; i < w; i++) begin
        u_src.send({96'h0, 32'((i * 2) % w)}, 1);
        get(32'((w - 1) / 2), i == w - 1);
      end
    end
    $display("t_med done");
  endtask
  task automatic t_chain;
    wr(12'h040, cw(`MC_P_THK, 4'h0, 4'h1, 16'h0), 2'h0);
    wr(12'h050, cw(`MC_P_SUM, 4'h4, 4'h2, 16'h0), 2'h0);
    wr(12'h054, 32'hfffd0002, 2'h0);
    wr(12'h058, 32'h5, 2'h0);
    wr(12'h060, cw(`MC_P_DUP, 4'h9, 4'h0, 16'h0), 2'h0);
    wr(12'h0d0, cw(`MC_P_DUP, 4'h5, 4'h0, 16'h0), 2'h0);
    wr(`MC_A_CTRL, 32'hd, 2'h0);
    u_src.send({32'h0, 32'h7, 32'h1e, 32'ha}, 2);
    get(32'h18);
    rd(12'h04c, 32'h14, 2'h0);
    rd(12'h06c, 32'ha, 2'h0);
    $display("t_chain done");
  endtask
  // Full FIFO with one more result parked
  task automatic t_fifo;
    wr(`MC_A_CTRL, 32'h0, 2'h0);
    for (int i = 1; i <= 8; i++) u_src.send({96'h0, 32'(i)}, 1);
    fork
      u_src.send({96'h0, 32'h9}, 1);
    join_none
    repeat (60) @(posedge core_clk);
    chk({31'h0, in_ready}, 32'h0);
    for (int i = 1; i <= 9; i++) get(32'(i));
    wait fork;
    $display("t_fifo done");
  endtask
  task automatic t_axi;
    rd(12'h008, 32'h0, 2'h2);
    wr(12'h008, 32'h1, 2'h2);
    wr(`MC_A_STAT, 32'hffffffff, 2'h0);
    rd(`MC_A_STAT, 32'h002f0000, 2'h0);
    wr(12'h048, 32'hffffffff, 2'h0);
    wr(12'h048, 32'h0, 2'h0, 4'h1);
    rd(12'h048, 32'hffffff00, 2'h0);
    $display("t_axi done");
  endtask
  task automatic conclude;
    $display("Checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ****************
  // Sequence and watchdog
  // ****************
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'h1;
    t_reset();
    t_mov();
    t_rec();
    t_med();
    t_chain();
    t_fifo();
    t_axi();
    conclude();
  end
  // Whole run needs under two thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    chk(32'h0, 32'h1);
    conclude();
  end
endmodule // mcavg_top_test
